// ==== ppcb_defines.vh ====
/*
 * Constants for the parallel-port configuration bridge: timing, states,
 * fixed pin levels and bit positions.
 * Assumes a 200 MHz clk_sys and inclusion by its bare name.
 */
//Operation
//- Done high switches into pass-through mode
//- Host data lines forwarded to FPGA pins
//- FPGA return lines relayed to S3, S4, S5
//- Flash enable low releases shared data lines
//- Decimal point shows valid configuration
//- Flash enable low stops driving decimal point
//- Flash enable high disables flash, frees lines
//- Device and FPGA never share flash access
//- Optional flash-to-FPGA load at power-up
//- Drive config bus, clock, program, select, strobe
//- Mode select 0 chooses mode; others fixed
//- Watch init, done and busy during load
//- Busy and strobes share test-port wiring
//- Display segments light on logic high
//- Switches low when closed; pick flash bank
`ifndef PPCB_DEFINES_VH
`define PPCB_DEFINES_VH

`define PPCB_CLK_NS       5
`define PPCB_T_PROG_NS    300
`define PPCB_T_FLASH_NS   120
// Least times round up to whole cycles
`define PPCB_PROG_CYC     ((`PPCB_T_PROG_NS + `PPCB_CLK_NS - 1) / `PPCB_CLK_NS)
`define PPCB_FLASH_CYC    ((`PPCB_T_FLASH_NS + `PPCB_CLK_NS - 1) / `PPCB_CLK_NS)
`define PPCB_CNT_W        8
`define PPCB_CONFIG_CLOCK_DIV     8'h02

`define PPCB_ST_W         4
`define PPCB_ST_RESET     4'h0
`define PPCB_ST_PROG      4'h1
`define PPCB_ST_WINIT     4'h2
`define PPCB_ST_FREAD     4'h3
`define PPCB_ST_WRITE     4'h4
`define PPCB_ST_CLKHI     4'h5
`define PPCB_ST_HOST      4'h6
`define PPCB_ST_PASS      4'h7
`define PPCB_ST_FAIL      4'h8
`define PPCB_ST_WDONE     4'h9

`define PPCB_M0_SERIAL    1'b0
`define PPCB_M0_PARALLEL  1'b1
`define PPCB_M1_LEVEL     1'b1
`define PPCB_M2_LEVEL     1'b0
`define PPCB_DP_BIT       1
`define PPCB_SER_BIT      0
`define PPCB_BIT_LAST     3'h7

`endif

// ==== ppcb_bridge.v ====
/*
 * Parallel-port configuration bridge: loads the FPGA from the host or from
 * flash, then links host data and status lines to the FPGA.
 * Assumes all pins except clk_sys and sys_rst are asynchronous; two-way pins are split
 * into input, output and output enable and resolved outside.
 */
`include "ppcb_defines.vh"
`default_nettype none
module ppcb_bridge #(
   parameter FADDR_W = 18,
   parameter SW_W    = 4
) (
   input  wire               clk_sys,
   input  wire               sys_rst,
   input  wire               auto_load,
   input  wire               serial_mode,
   input  wire [7:0]         pp_data,
   input  wire               pp_strobe,
   output reg  [2:0]         pp_status,
   input  wire [2:0]         fpga_ret,
   output reg  [7:0]         pt_o,
   output reg                pt_oe,
   input  wire [7:0]         bus_i,
   output reg  [7:0]         bus_o,
   output reg  [7:0]         bus_oe,
   input  wire [SW_W-1:0]    flash_addr_i,
   output reg  [FADDR_W-1:0] flash_addr_o,
   output reg                flash_addr_oe,
   input  wire               flash_ce_n_i,
   output reg                flash_ce_n_o,
   output reg                flash_ce_n_oe,
   output reg                flash_oe_n,
   output reg                flash_we_n,
   output reg                config_clock,
   output reg                cfg_prog_n,
   output reg                cfg_cs_n,
   output reg                cfg_wr_n,
   output reg                config_mode_select_0,
   output reg                config_mode_select_1,
   output reg                config_mode_select_2,
   input  wire               cfg_init_n,
   input  wire               cfg_done,
   input  wire               config_busy_serial_out,
   output reg                cfg_active,
   output reg                cfg_fail,
   output reg                pass_mode
);

   localparam LOW_W = FADDR_W - SW_W;

   // Two-stage synchronisers; first stages feed only second stages
   reg [7:0]         pp_data_s1_r;
   reg [7:0]         pp_data_r;
   reg               strobe_s1_r;
   reg               strobe_r;
   reg               strobe_d_r;
   reg [2:0]         ret_s1_r;
   reg [2:0]         ret_r;
   reg [2:0]         ctl_s1_r;
   reg [2:0]         ctl_r;
   reg               busy_s1_r;
   reg               busy_r;
   reg               ce_s1_r;
   reg               ce_r;
   reg [7:0]         bus_s1_r;
   reg [7:0]         bus_r;
   reg [SW_W-1:0]    sw_s1_r;
   reg [SW_W-1:0]    sw_r;
   reg [1:0]         mode_s1_r;
   reg [1:0]         mode_r;

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         pp_data_s1_r <= 8'h00;
         pp_data_r    <= 8'h00;
         strobe_s1_r  <= 1'b0;
         strobe_r     <= 1'b0;
         strobe_d_r   <= 1'b0;
         ret_s1_r     <= 3'h0;
         ret_r        <= 3'h0;
         ctl_s1_r     <= 3'h0;
         ctl_r        <= 3'h0;
         busy_s1_r    <= 1'b0;
         busy_r       <= 1'b0;
         ce_s1_r      <= 1'b1;
         ce_r         <= 1'b1;
         bus_s1_r     <= 8'h00;
         bus_r        <= 8'h00;
      end else begin
         pp_data_s1_r <= pp_data;
         pp_data_r    <= pp_data_s1_r;
         strobe_s1_r  <= pp_strobe;
         strobe_r     <= strobe_s1_r;
         strobe_d_r   <= strobe_r;
         ret_s1_r     <= fpga_ret;
         ret_r        <= ret_s1_r;
         ctl_s1_r     <= {cfg_done, cfg_init_n, 1'b0};
         ctl_r        <= ctl_s1_r;
         busy_s1_r    <= config_busy_serial_out;
         busy_r       <= busy_s1_r;
         ce_s1_r      <= flash_ce_n_i;
         ce_r         <= ce_s1_r;
         bus_s1_r     <= bus_i;
         bus_r        <= bus_s1_r;
      end
   end

   // Straps keep sampling through reset so the RESET state sees settled values
   always @(posedge clk_sys) begin
      sw_s1_r   <= flash_addr_i;
      sw_r      <= sw_s1_r;
      mode_s1_r <= {serial_mode, auto_load};
      mode_r    <= mode_s1_r;
   end

   wire done_w     = ctl_r[2];
   wire init_n_w   = ctl_r[1];
   wire strobe_rise = strobe_r & ~strobe_d_r;
   wire ser_w      = mode_r[1];
   wire auto_w     = mode_r[0];

   // Configuration clock rate as a one-cycle enable
   reg  [`PPCB_CNT_W-1:0] div_r;
   wire                   config_clock_en = (div_r == `PPCB_CONFIG_CLOCK_DIV);

   always @(posedge clk_sys) begin
      if (sys_rst || config_clock_en)
         div_r <= {`PPCB_CNT_W{1'b0}};
      else
         div_r <= div_r + 1'b1;
   end

   reg [`PPCB_ST_W-1:0]  st_r;
   reg [`PPCB_CNT_W-1:0] cnt_r;
   reg [7:0]             byte_r;
   reg [2:0]             bit_r;
   reg [LOW_W-1:0]       low_r;
   reg [SW_W-1:0]        bank_r;
   reg                   from_flash_r;
   reg                   ser_r;

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r         <= `PPCB_ST_RESET;
         cnt_r        <= {`PPCB_CNT_W{1'b0}};
         byte_r       <= 8'h00;
         bit_r        <= 3'h0;
         low_r        <= {LOW_W{1'b0}};
         bank_r       <= {SW_W{1'b0}};
         from_flash_r <= 1'b0;
         ser_r        <= 1'b0;
         cfg_prog_n   <= 1'b1;
         cfg_cs_n     <= 1'b1;
         cfg_wr_n     <= 1'b1;
         config_clock <= 1'b0;
         flash_ce_n_o <= 1'b1;
         flash_oe_n   <= 1'b1;
         flash_we_n   <= 1'b1;
         cfg_fail     <= 1'b0;
      end else begin
         case (st_r)
            `PPCB_ST_RESET: begin
               // Straps caught after reset release
               from_flash_r <= auto_w;
               ser_r        <= ser_w;
               bank_r       <= sw_r;
               cfg_prog_n   <= 1'b0;
               cnt_r        <= {`PPCB_CNT_W{1'b0}};
               st_r         <= `PPCB_ST_PROG;
            end
            `PPCB_ST_PROG: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == `PPCB_PROG_CYC - 1) begin
                  cfg_prog_n <= 1'b1;
                  st_r       <= `PPCB_ST_WINIT;
               end
            end
            `PPCB_ST_WINIT: begin
               if (init_n_w)
                  st_r <= from_flash_r ? `PPCB_ST_FREAD : `PPCB_ST_HOST;
               cnt_r <= {`PPCB_CNT_W{1'b0}};
            end
            `PPCB_ST_FREAD: begin
               // Device owns flash only while the FPGA is unconfigured
               flash_ce_n_o <= 1'b0;
               flash_oe_n   <= 1'b0;
               cnt_r        <= cnt_r + 1'b1;
               if (cnt_r == `PPCB_FLASH_CYC + 1) begin
                  byte_r       <= bus_r;
                  flash_ce_n_o <= 1'b1;
                  flash_oe_n   <= 1'b1;
                  low_r        <= low_r + 1'b1;
                  bit_r        <= 3'h0;
                  st_r         <= `PPCB_ST_WRITE;
               end
            end
            `PPCB_ST_HOST: begin
               // Host paces bytes; S3 tells it when the bridge is ready
               if (done_w)
                  st_r <= `PPCB_ST_PASS;
               else if (strobe_rise) begin
                  byte_r <= pp_data_r;
                  bit_r  <= 3'h0;
                  st_r   <= `PPCB_ST_WRITE;
               end
            end
            `PPCB_ST_WRITE: begin
               cfg_cs_n <= ser_r;
               cfg_wr_n <= ser_r;
               // Busy only means busy while select is low; else it is test wiring
               if (config_clock_en && !(busy_r && !cfg_cs_n)) begin
                  config_clock <= 1'b1;
                  st_r         <= `PPCB_ST_CLKHI;
               end
            end
            `PPCB_ST_CLKHI: begin
               if (config_clock_en) begin
                  config_clock <= 1'b0;
                  if (!init_n_w) begin
                     cfg_fail <= 1'b1;
                     cfg_cs_n <= 1'b1;
                     cfg_wr_n <= 1'b1;
                     st_r     <= `PPCB_ST_FAIL;
                  end else if (ser_r && bit_r != `PPCB_BIT_LAST) begin
                     bit_r <= bit_r + 1'b1;
                     st_r  <= `PPCB_ST_WRITE;
                  end else begin
                     cfg_cs_n <= 1'b1;
                     cfg_wr_n <= 1'b1;
                     cnt_r    <= {`PPCB_CNT_W{1'b0}};
                     if (!from_flash_r)
                        st_r <= `PPCB_ST_HOST;
                     else if (low_r == {LOW_W{1'b0}})
                        st_r <= `PPCB_ST_WDONE;
                     else
                        st_r <= `PPCB_ST_FREAD;
                  end
               end
            end
            `PPCB_ST_WDONE: begin
               if (done_w)
                  st_r <= `PPCB_ST_PASS;
               else if (!init_n_w) begin
                  cfg_fail <= 1'b1;
                  st_r     <= `PPCB_ST_FAIL;
               end
            end
            `PPCB_ST_PASS: begin
               if (!done_w)
                  st_r <= `PPCB_ST_WINIT;
            end
            `PPCB_ST_FAIL: begin
               if (done_w)
                  st_r <= `PPCB_ST_PASS;
            end
            default: st_r <= `PPCB_ST_RESET;
         endcase
         // Done ends any load early, e.g. a short image in flash
         // Done seen in reset or the program pulse is stale from the last image
         if (done_w && st_r != `PPCB_ST_PASS && st_r != `PPCB_ST_WINIT &&
             st_r != `PPCB_ST_RESET && st_r != `PPCB_ST_PROG) begin
            st_r         <= `PPCB_ST_PASS;
            cfg_cs_n     <= 1'b1;
            cfg_wr_n     <= 1'b1;
            config_clock <= 1'b0;
            flash_ce_n_o <= 1'b1;
            flash_oe_n   <= 1'b1;
         end
      end
   end

   wire in_pass  = (st_r == `PPCB_ST_PASS);
   wire in_fread = (st_r == `PPCB_ST_FREAD);
   wire fpga_ce  = in_pass && !ce_r;
   wire [7:0] ser_byte = byte_r >> bit_r;

   // Pin drivers, all registered
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         pp_status            <= 3'h0;
         pt_o                 <= 8'h00;
         pt_oe                <= 1'b0;
         bus_o                <= 8'h00;
         bus_oe               <= 8'h00;
         flash_addr_o         <= {FADDR_W{1'b0}};
         flash_addr_oe        <= 1'b0;
         flash_ce_n_oe        <= 1'b0;
         config_mode_select_0 <= `PPCB_M0_PARALLEL;
         config_mode_select_1 <= `PPCB_M1_LEVEL;
         config_mode_select_2 <= `PPCB_M2_LEVEL;
         cfg_active           <= 1'b0;
         pass_mode            <= 1'b0;
      end else begin
         config_mode_select_0 <= ser_r ? `PPCB_M0_SERIAL : `PPCB_M0_PARALLEL;
         config_mode_select_1 <= `PPCB_M1_LEVEL;
         config_mode_select_2 <= `PPCB_M2_LEVEL;
         pass_mode  <= in_pass;
         cfg_active <= !in_pass && st_r != `PPCB_ST_FAIL;
         flash_addr_o  <= {bank_r, low_r};
         flash_addr_oe <= in_fread;
         // Flash stays disabled by the device outside reset and pass mode, except during its own reads
         flash_ce_n_oe <= !in_pass;
         if (in_pass) begin
            // FPGA keeps off these pins unless its flash enable is low
            pt_o      <= pp_data_r;
            pt_oe     <= ce_r;
            pp_status <= ret_r;
            bus_o     <= 8'h00;
            bus_o[`PPCB_DP_BIT]  <= 1'b1;
            bus_oe    <= 8'h00;
            bus_oe[`PPCB_DP_BIT] <= !fpga_ce;
         end else begin
            // Pass-through paths idle; bus carries only configuration bytes
            pt_o      <= 8'h00;
            pt_oe     <= 1'b0;
            pp_status <= {cfg_fail, init_n_w, st_r == `PPCB_ST_HOST};
            bus_o     <= ser_r ? {7'h00, ser_byte[`PPCB_SER_BIT]} : byte_r;
            bus_oe    <= in_fread ? 8'h00 : 8'hFF;
         end
      end
   end

endmodule
`default_nettype wire

// ==== ppcb_fpga_model.sv ====
/*
 * Behavioural model of the FPGA's configuration port.
 * Assumes the bridge drives program, clock, select and strobe; done follows a set byte count.
 */
`default_nettype none
module ppcb_fpga_model #(
   parameter int NBYTES = 2
) (
   input  wire logic cfg_prog_n,
   input  wire logic config_clock,
   input  wire logic cfg_cs_n,
   input  wire logic cfg_wr_n,
   output var  logic cfg_init_n,
   output var  logic cfg_done,
   output wire logic config_busy_serial_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int   n_bytes;
   logic tog;
   initial begin
      tog = 1'b0;
      cfg_init_n = 1'b1;
      cfg_done = 1'b0;
      n_bytes = 0;
   end
   // Busy toggles off select, test wiring shares it
   always #7 tog = ~tog;
   assign config_busy_serial_out = cfg_cs_n ? tog : 1'b0;
   // Program pulse clears the load
   always @(negedge cfg_prog_n) begin
      cfg_init_n <= #1 1'b0;
      cfg_done <= #1 1'b0;
      n_bytes = 0;
   end
   always @(posedge cfg_prog_n) cfg_init_n <= #200 1'b1;
   // Never drives the shared bus; flash use is left to the bench
   always @(posedge config_clock) begin
      if (cfg_prog_n === 1'b1 && cfg_cs_n === 1'b0 && cfg_wr_n === 1'b0) begin
         n_bytes = n_bytes + 1;
         if (n_bytes >= NBYTES) cfg_done <= #1 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== ppcb_bridge_properties.sv ====
/*
 * Port checker for the configuration bridge.
 * Assumes binding into ppcb_bridge, one clk_sys domain, sys_rst synchronous.
 */
`default_nettype none
module ppcb_bridge_chk #(
   parameter FADDR_W = 18,
   parameter SW_W    = 4
) (
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic [7:0] pp_data,
   input wire logic [2:0] pp_status,
   input wire logic [2:0] fpga_ret,
   input wire logic [7:0] pt_o,
   input wire logic       pt_oe,
   input wire logic [7:0] bus_oe,
   input wire logic       flash_ce_n_i,
   input wire logic       flash_ce_n_o,
   input wire logic       flash_ce_n_oe,
   input wire logic       flash_oe_n,
   input wire logic       flash_addr_oe,
   input wire logic       cfg_prog_n,
   input wire logic       cfg_cs_n,
   input wire logic       cfg_wr_n,
   input wire logic       config_mode_select_1,
   input wire logic       config_mode_select_2,
   input wire logic       cfg_done,
   input wire logic       cfg_active,
   input wire logic       pass_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   chk_pass_cause: assert property ($rose(pass_mode) |-> $past(cfg_done))
      else $error("pass mode entered without done");
   chk_pass_entry: assert property (
      $rose(cfg_done) && cfg_active |-> ##[1:20] pass_mode)
      else $error("done did not lead to pass mode");
   chk_data_thru: assert property (
      (pass_mode && $stable(pp_data))[*4] |-> pt_o == pp_data)
      else $error("host data not forwarded");
   chk_status_relay: assert property (
      (pass_mode && $stable(fpga_ret))[*4] |-> pp_status == fpga_ret)
      else $error("return lines not relayed");
   chk_data_release: assert property ((!flash_ce_n_i)[*3] |=> !pt_oe)
      else $error("data lines held during flash use");
   chk_dp_release: assert property ((!flash_ce_n_i)[*3] |=> !bus_oe[1])
      else $error("decimal point held during flash use");
   chk_early_quiet: assert property (!pass_mode |-> !pt_oe)
      else $error("pass path active before done");
   chk_mode_fixed: assert property (config_mode_select_1 && !config_mode_select_2)
      else $error("fixed mode pins wrong");
   chk_prog_pulse: assert property ($fell(cfg_prog_n) |-> !cfg_prog_n[*8])
      else $error("program pulse too short");
   chk_strobe_sel: assert property (!cfg_wr_n |-> !cfg_cs_n)
      else $error("write strobe without select");
   chk_own_read: assert property (
      flash_ce_n_oe && !flash_ce_n_o |-> cfg_active && !pass_mode)
      else $error("flash enabled outside loading");
   chk_read_drive: assert property (
      !flash_oe_n |-> flash_ce_n_oe && !flash_ce_n_o && flash_addr_oe)
      else $error("flash read without enable and address");
   cover property ($rose(pass_mode));
   cover property (pass_mode && $fell(pt_oe));
   cover property ($fell(flash_oe_n));
endmodule
bind ppcb_bridge ppcb_bridge_chk #(.FADDR_W(FADDR_W), .SW_W(SW_W)) u_ppcb_bridge_chk (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .pp_data(pp_data), .pp_status(pp_status),
   .fpga_ret(fpga_ret), .pt_o(pt_o), .pt_oe(pt_oe), .bus_oe(bus_oe),
   .flash_ce_n_i(flash_ce_n_i), .flash_ce_n_o(flash_ce_n_o), .flash_ce_n_oe(flash_ce_n_oe),
   .flash_oe_n(flash_oe_n), .flash_addr_oe(flash_addr_oe), .cfg_prog_n(cfg_prog_n),
   .cfg_cs_n(cfg_cs_n), .cfg_wr_n(cfg_wr_n), .config_mode_select_1(config_mode_select_1),
   .config_mode_select_2(config_mode_select_2), .cfg_done(cfg_done),
   .cfg_active(cfg_active), .pass_mode(pass_mode));
`default_nettype wire

// ==== tb.sv ====
/*
 * Self-checking bench: host download, pass-through, flash hand-over, flash load.
 * Assumes the FPGA model in ppcb_fpga_model; shared lines resolve with pull-ups.
 */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        sys_rst, auto_load, serial_mode, pp_strobe, fpga_ce_n;
   logic [7:0]  pp_data, pt_o, bus_o, bus_oe;
   logic [2:0]  pp_status, fpga_ret;
   logic [3:0]  flash_addr_i;
   logic [17:0] flash_addr_o;
   logic        pt_oe, flash_addr_oe, flash_ce_n_o, flash_ce_n_oe, flash_oe_n, flash_we_n;
   logic        config_clock, cfg_prog_n, cfg_cs_n, cfg_wr_n, cfg_init_n, cfg_done;
   logic        config_mode_select_0, config_mode_select_1, config_mode_select_2;
   logic        config_busy_serial_out, cfg_active, cfg_fail, pass_mode;
   wire  [7:0]  bus_i = (bus_oe & bus_o) | ~bus_oe;
   wire         flash_ce_n_i = flash_ce_n_oe ? flash_ce_n_o : fpga_ce_n;
   int          num_errors = 0;
   int          cmp_count = 0;
   int          i, k;
   always #2.5 clk_sys = ~clk_sys;
   ppcb_bridge u_ppcb_bridge (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .auto_load(auto_load), .serial_mode(serial_mode),
      .pp_data(pp_data), .pp_strobe(pp_strobe), .pp_status(pp_status), .fpga_ret(fpga_ret),
      .pt_o(pt_o), .pt_oe(pt_oe), .bus_i(bus_i), .bus_o(bus_o), .bus_oe(bus_oe),
      .flash_addr_i(flash_addr_i), .flash_addr_o(flash_addr_o), .flash_addr_oe(flash_addr_oe),
      .flash_ce_n_i(flash_ce_n_i), .flash_ce_n_o(flash_ce_n_o), .flash_ce_n_oe(flash_ce_n_oe),
      .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .config_clock(config_clock),
      .cfg_prog_n(cfg_prog_n), .cfg_cs_n(cfg_cs_n), .cfg_wr_n(cfg_wr_n),
      .config_mode_select_0(config_mode_select_0), .config_mode_select_1(config_mode_select_1),
      .config_mode_select_2(config_mode_select_2), .cfg_init_n(cfg_init_n),
      .cfg_done(cfg_done), .config_busy_serial_out(config_busy_serial_out),
      .cfg_active(cfg_active), .cfg_fail(cfg_fail), .pass_mode(pass_mode));
   ppcb_fpga_model u_ppcb_fpga_model (
      .cfg_prog_n(cfg_prog_n), .config_clock(config_clock), .cfg_cs_n(cfg_cs_n),
      .cfg_wr_n(cfg_wr_n), .cfg_init_n(cfg_init_n), .cfg_done(cfg_done),
      .config_busy_serial_out(config_busy_serial_out));
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic do_reset(input logic al, input logic sm);
      auto_load = al;
      serial_mode = sm;
      sys_rst = 1'b1;
      repeat (12) @(negedge clk_sys);
      check({cfg_prog_n, flash_ce_n_o, flash_we_n, pt_oe}, 4'hE);
      check({config_mode_select_0, config_mode_select_1, config_mode_select_2}, 3'h6);
      sys_rst = 1'b0;
   endtask
   // Strobe period 64 ns; the bridge answers inside the high phase, so watch alongside
   task automatic host_byte(input logic [7:0] b);
      for (i = 0; i < 400 && pp_status[0] !== 1'b1; i++) @(negedge clk_sys);
      check(pp_status[0], 1'b1);
      pp_data = b;
      fork
         #32 pp_strobe = 1'b1;
         #64 pp_strobe = 1'b0;
         begin
            for (i = 0; i < 100 && cfg_wr_n !== 1'b0; i++) @(negedge clk_sys);
            check({cfg_wr_n, cfg_cs_n, bus_o}, {2'h0, b});
            for (i = 0; i < 20 && config_clock !== 1'b1; i++) @(negedge clk_sys);
            check(config_clock, 1'b1);
         end
      join
   endtask
   initial begin
      {sys_rst, auto_load, serial_mode, pp_strobe} = 4'h8;
      pp_data = 8'h00;
      fpga_ret = 3'h0;
      // Bank switches, closed reads low
      flash_addr_i = 4'hA;
      fpga_ce_n = 1'b1;
      // Test-port lines and S6 never pass through the bridge
      do_reset(1'b0, 1'b0);
      for (i = 0; i < 400 && pp_status[0] !== 1'b1; i++) @(negedge clk_sys);
      check({pass_mode, pt_oe, cfg_active, config_mode_select_0}, 4'h3);
      check({cfg_fail, pp_status}, 4'h3);
      host_byte(8'hA5);
      host_byte(8'h3C);
      for (i = 0; i < 100 && pass_mode !== 1'b1; i++) @(negedge clk_sys);
      check({pass_mode, pt_oe, bus_o[1], bus_oe[1]}, 4'hF);
      for (k = 0; k < 8; k++) begin
         pp_data = 8'hA5 ^ (8'h01 << k);
         fpga_ret = k[2:0];
         repeat (4) @(negedge clk_sys);
         check(pt_o, 8'hA5 ^ (8'h01 << k));
         check(pp_status, k[2:0]);
      end
      // FPGA lowers flash enable only for its own flash use
      fpga_ce_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      check({pt_oe, bus_oe[1], flash_ce_n_oe}, 3'h0);
      fpga_ce_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      check({pt_oe, bus_oe[1]}, 2'h3);
      do_reset(1'b1, 1'b1);
      repeat (3) @(negedge clk_sys);
      check(config_mode_select_0, 1'b0);
      for (i = 0; i < 1000 && flash_oe_n !== 1'b0; i++) @(negedge clk_sys);
      check({flash_ce_n_o, flash_ce_n_oe, flash_oe_n}, 3'h2);
      check({flash_addr_oe, cfg_fail}, 2'h2);
      check(flash_addr_o[17:14], 4'hA);
      final_report;
   end
   initial begin
      #100000;
      num_errors++;
      final_report;
   end
endmodule
`default_nettype wire
